//--- design/csx_pkg.sv
// Constants and types for the control, shadow-set and exclusive-or executor.
// Operation
// - Control-write copies src_a into control_reg_n.
// - Control index field separate from src_a operand.
// - Control-write is primary 0x3a, extended 0x2e.
// - Previous-set write copies src_a into previous-set dest_c.
// - Previous-set write may write the zero_register.
// - Destination set comes from previous_set_field.
// - previous_set_field holds set active before exception.
// - Without shadow sets, previous-set write is illegal.
// - Previous-set write is primary 0x3a, extended 0x14.
// - Exclusive-or writes src_a xor src_b to dest_c.
// - Exclusive-or is primary 0x3a, extended 0x1e, never faults.
package csx_pkg;
    localparam int DATA_W = 32;
    localparam int REG_IDX_W = 5;
    localparam int OPX_W = 6;
    localparam int OP_W = 6;
    localparam int SRC_A_LSB = 27;
    localparam int SRC_B_LSB = 22;
    localparam int DEST_C_LSB = 17;
    localparam int OPX_LSB = 11;
    localparam int CTL_N_LSB = 6;
    localparam int OP_LSB = 0;
    localparam logic [OP_W-1:0] OP_RTYPE = 6'h3a;
    localparam logic [OPX_W-1:0] OPX_WR_CTL = 6'h2e;
    localparam logic [OPX_W-1:0] OPX_WR_PREV = 6'h14;
    localparam logic [OPX_W-1:0] OPX_XOR = 6'h1e;
    localparam logic [REG_IDX_W-1:0] CTL_STATUS_IDX = 5'h00;
    localparam int PREV_SET_LSB = 10;
    localparam int SET_W_MAX = 6;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_WR_CTL,
        OP_WR_PREV,
        OP_XOR_RR
    } csx_op_t;
endpackage

//--- design/csx_shadow_mem.sv
// Storage for the shadow register sets, with a registered read port.
`timescale 1ns/1ps
`default_nettype none
module csx_shadow_mem
    import csx_pkg::*;
#(
    parameter int SET_W = 2,
    parameter int WORDS = 128
) (
    input wire logic ref_clk_i,
    input wire logic wr_en_i,
    input wire logic [SET_W+REG_IDX_W-1:0] wr_addr_i,
    input wire logic [DATA_W-1:0] wr_data_i,
    input wire logic [SET_W+REG_IDX_W-1:0] rd_addr_i,
    output logic [DATA_W-1:0] rd_data_o
);
    // No reset on the array: software must clear each zero_register itself.
    logic [DATA_W-1:0] mem_reg [WORDS];

    always_ff @(posedge ref_clk_i) begin
        if (wr_en_i) begin
            mem_reg[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem_reg[rd_addr_i];
    end
endmodule // csx_shadow_mem
`default_nettype wire

//--- design/csx_exec.sv
// Decoder and executor for control-write, previous-set write and exclusive-or.
`timescale 1ns/1ps
`default_nettype none
module csx_exec
    import csx_pkg::*;
#(
    parameter bit HAS_SHADOW = 1'b1,
    parameter int SET_W = 2
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic instr_valid_i,
    input wire logic [DATA_W-1:0] instr_i,
    input wire logic user_mode_i,
    input wire logic [DATA_W-1:0] src_a_data_i,
    input wire logic [DATA_W-1:0] src_b_data_i,
    input wire logic exc_switch_i,
    input wire logic [SET_W-1:0] exc_new_set_i,
    input wire logic [SET_W-1:0] shd_rd_set_i,
    input wire logic [REG_IDX_W-1:0] shd_rd_idx_i,
    output logic ctl_wr_o,
    output logic [REG_IDX_W-1:0] ctl_idx_o,
    output logic [DATA_W-1:0] ctl_data_o,
    output logic gpr_wr_o,
    output logic [REG_IDX_W-1:0] gpr_idx_o,
    output logic [DATA_W-1:0] gpr_data_o,
    output logic shd_wr_o,
    output logic exc_supv_o,
    output logic exc_illegal_o,
    output logic [SET_W-1:0] cur_set_o,
    output logic [SET_W-1:0] prev_set_o,
    output logic [DATA_W-1:0] shd_rd_data_o
);
    localparam int WORDS = (1 << SET_W) * (1 << REG_IDX_W);
    localparam int ADDR_W = SET_W + REG_IDX_W;

    // Field split of the R-type word.
    logic [REG_IDX_W-1:0] f_src_a;
    logic [REG_IDX_W-1:0] f_dest_c;
    logic [REG_IDX_W-1:0] f_ctl_n;
    logic [OPX_W-1:0] f_opx;
    logic [OP_W-1:0] f_op;
    csx_op_t op;

    assign f_src_a = instr_i[SRC_A_LSB +: REG_IDX_W];
    assign f_dest_c = instr_i[DEST_C_LSB +: REG_IDX_W];
    assign f_ctl_n = instr_i[CTL_N_LSB +: REG_IDX_W];
    assign f_opx = instr_i[OPX_LSB +: OPX_W];
    assign f_op = instr_i[OP_LSB +: OP_W];

    always_comb begin
        op = OP_NONE;
        if (instr_valid_i && f_op == OP_RTYPE) begin
            unique case (f_opx)
                OPX_WR_CTL: op = OP_WR_CTL;
                OPX_WR_PREV: op = OP_WR_PREV;
                OPX_XOR: op = OP_XOR_RR;
                default: op = OP_NONE;
            endcase
        end
    end

    // Result registers.
    logic ctl_wr_reg, ctl_wr_next;
    logic [REG_IDX_W-1:0] ctl_idx_reg, ctl_idx_next;
    logic [DATA_W-1:0] ctl_data_reg, ctl_data_next;
    logic gpr_wr_reg, gpr_wr_next;
    logic [REG_IDX_W-1:0] gpr_idx_reg, gpr_idx_next;
    logic [DATA_W-1:0] gpr_data_reg, gpr_data_next;
    logic shd_wr_reg, shd_wr_next;
    logic [ADDR_W-1:0] shd_addr_reg, shd_addr_next;
    logic [DATA_W-1:0] shd_data_reg, shd_data_next;
    logic exc_supv_reg, exc_supv_next;
    logic exc_illegal_reg, exc_illegal_next;
    logic [SET_W-1:0] cur_set_reg, cur_set_next;
    logic [SET_W-1:0] prev_set_reg, prev_set_next;
    logic status_wr;

    always_comb begin
        ctl_wr_next = 1'b0;
        ctl_idx_next = ctl_idx_reg;
        ctl_data_next = ctl_data_reg;
        gpr_wr_next = 1'b0;
        gpr_idx_next = gpr_idx_reg;
        gpr_data_next = gpr_data_reg;
        shd_wr_next = 1'b0;
        shd_addr_next = shd_addr_reg;
        shd_data_next = shd_data_reg;
        exc_supv_next = 1'b0;
        exc_illegal_next = 1'b0;
        unique case (op)
            OP_NONE: begin
            end
            OP_WR_CTL: begin
                if (user_mode_i) begin
                    exc_supv_next = 1'b1;
                end else begin
                    ctl_wr_next = 1'b1;
                    ctl_idx_next = f_ctl_n;
                    ctl_data_next = src_a_data_i;
                end
            end
            OP_WR_PREV: begin
                // Illegal outranks the privilege check when no shadow sets exist.
                if (!HAS_SHADOW) begin
                    exc_illegal_next = 1'b1;
                end else if (user_mode_i) begin
                    exc_supv_next = 1'b1;
                end else begin
                    // Index zero is written like any other, unlike the normal file.
                    shd_wr_next = 1'b1;
                    shd_addr_next = {prev_set_reg, f_dest_c};
                    shd_data_next = src_a_data_i;
                end
            end
            OP_XOR_RR: begin
                gpr_wr_next = 1'b1;
                gpr_idx_next = f_dest_c;
                gpr_data_next = src_a_data_i ^ src_b_data_i;
            end
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            ctl_wr_reg <= 1'b0;
            ctl_idx_reg <= '0;
            ctl_data_reg <= '0;
            gpr_wr_reg <= 1'b0;
            gpr_idx_reg <= '0;
            gpr_data_reg <= '0;
            shd_wr_reg <= 1'b0;
            shd_addr_reg <= '0;
            shd_data_reg <= '0;
            exc_supv_reg <= 1'b0;
            exc_illegal_reg <= 1'b0;
        end else begin
            ctl_wr_reg <= ctl_wr_next;
            ctl_idx_reg <= ctl_idx_next;
            ctl_data_reg <= ctl_data_next;
            gpr_wr_reg <= gpr_wr_next;
            gpr_idx_reg <= gpr_idx_next;
            gpr_data_reg <= gpr_data_next;
            shd_wr_reg <= shd_wr_next;
            shd_addr_reg <= shd_addr_next;
            shd_data_reg <= shd_data_next;
            exc_supv_reg <= exc_supv_next;
            exc_illegal_reg <= exc_illegal_next;
        end
    end

    // Register-set tracking: current set and previous_set_field.
    assign status_wr = (op == OP_WR_CTL) && !user_mode_i && (f_ctl_n == CTL_STATUS_IDX);

    always_comb begin
        cur_set_next = cur_set_reg;
        prev_set_next = prev_set_reg;
        // An exception wins over a status write in the same cycle, since it
        // must record the set that was live when it struck.
        if (exc_switch_i) begin
            prev_set_next = cur_set_reg;
            cur_set_next = exc_new_set_i;
        end else if (status_wr) begin
            prev_set_next = src_a_data_i[PREV_SET_LSB +: SET_W];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cur_set_reg <= '0;
            prev_set_reg <= '0;
        end else begin
            cur_set_reg <= cur_set_next;
            prev_set_reg <= prev_set_next;
        end
    end

    csx_shadow_mem #(
        .SET_W(SET_W),
        .WORDS(WORDS)
    ) u_shadow (
        .ref_clk_i(ref_clk_i),
        .wr_en_i(shd_wr_reg),
        .wr_addr_i(shd_addr_reg),
        .wr_data_i(shd_data_reg),
        .rd_addr_i({shd_rd_set_i, shd_rd_idx_i}),
        .rd_data_o(shd_rd_data_o)
    );

    assign ctl_wr_o = ctl_wr_reg;
    assign ctl_idx_o = ctl_idx_reg;
    assign ctl_data_o = ctl_data_reg;
    assign gpr_wr_o = gpr_wr_reg;
    assign gpr_idx_o = gpr_idx_reg;
    assign gpr_data_o = gpr_data_reg;
    assign shd_wr_o = shd_wr_reg;
    assign exc_supv_o = exc_supv_reg;
    assign exc_illegal_o = exc_illegal_reg;
    assign cur_set_o = cur_set_reg;
    assign prev_set_o = prev_set_reg;

    // Checks.
    sequence s_priv_wr_ctl;
        instr_valid_i && f_op == OP_RTYPE && f_opx == OPX_WR_CTL && !user_mode_i;
    endsequence

    sequence s_priv_wr_prev;
        instr_valid_i && f_op == OP_RTYPE && f_opx == OPX_WR_PREV && !user_mode_i;
    endsequence

    sequence s_xor_word;
        instr_valid_i && f_op == OP_RTYPE && f_opx == OPX_XOR;
    endsequence

    chk_ctl_write_data: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        s_priv_wr_ctl |=> ctl_wr_o && ctl_data_o == $past(src_a_data_i) && !gpr_wr_o)
        else $error("control write did not carry src_a");

    chk_ctl_index_field: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        s_priv_wr_ctl |=> ctl_idx_o == $past(instr_i[CTL_N_LSB +: REG_IDX_W]))
        else $error("control index not taken from its own field");

    chk_prev_set_target: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        s_priv_wr_prev ##0 (HAS_SHADOW && !exc_switch_i)
        |=> shd_wr_o && shd_addr_reg == {$past(prev_set_reg), $past(f_dest_c)}
            && shd_data_reg == $past(src_a_data_i))
        else $error("previous-set write went to the wrong place");

    chk_zero_reg_write: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        s_priv_wr_prev ##0 (HAS_SHADOW && f_dest_c == '0)
        |=> shd_wr_o && shd_addr_reg[REG_IDX_W-1:0] == '0)
        else $error("write to the zero_register of a shadow set was dropped");

    chk_prev_set_track: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        exc_switch_i |=> prev_set_o == $past(cur_set_reg) && cur_set_o == $past(exc_new_set_i))
        else $error("exception did not record the previous set");

    chk_status_load: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        s_priv_wr_ctl ##0 (f_ctl_n == CTL_STATUS_IDX && !exc_switch_i)
        |=> prev_set_o == $past(src_a_data_i[PREV_SET_LSB +: SET_W]))
        else $error("status write did not load previous_set_field");

    chk_no_shadow_illegal: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (instr_valid_i && f_op == OP_RTYPE && f_opx == OPX_WR_PREV && !HAS_SHADOW)
        |=> exc_illegal_o && !shd_wr_o)
        else $error("previous-set write without shadow sets was not illegal");

    chk_xor_result: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        s_xor_word |=> gpr_wr_o && gpr_idx_o == $past(f_dest_c)
            && gpr_data_o == ($past(src_a_data_i) ^ $past(src_b_data_i))
            && !exc_supv_o && !exc_illegal_o)
        else $error("exclusive-or result wrong or faulted");

    chk_user_blocked: assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (instr_valid_i && f_op == OP_RTYPE && user_mode_i
            && (f_opx == OPX_WR_CTL || (f_opx == OPX_WR_PREV && HAS_SHADOW)))
        |=> exc_supv_o && !ctl_wr_o && !shd_wr_o && $stable(prev_set_o) [*1])
        else $error("user-mode privileged write was not blocked");
endmodule // csx_exec
`default_nettype wire

//--- verif/ctl_shadow_xor_exec_bench.sv
// Self-checking bench for the control-write, previous-set write and exclusive-or executor.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module ctl_shadow_xor_exec_bench;
    import csx_pkg::*;
    typedef struct {
        logic [31:0] ins;
        logic usr;
        logic [31:0] a;
        logic [31:0] b;
        logic [3:0] pls;
        logic [4:0] idx;
        logic [31:0] dat;
        logic ill;
    } csx_row_t;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic valid = 1'b0;
    logic usr = 1'b0;
    logic exc_sw = 1'b0;
    logic [1:0] exc_set = 2'h0;
    logic [1:0] rd_set = 2'h0;
    logic [4:0] rd_idx = 5'h00;
    logic [31:0] ins = 32'h0, a = 32'h0, b = 32'h0;
    logic ctl_wr, gpr_wr, shd_wr, supv, ill, ill2, shd_wr2;
    logic [4:0] ctl_idx, gpr_idx;
    logic [31:0] ctl_data, gpr_data, rd_data;
    logic [1:0] cur_set, prev_set;
    int errors = 0;
    int checks = 0;
    csx_row_t rows[9];
    always #2 ref_clk_i = ~ref_clk_i;
    csx_exec #(.HAS_SHADOW(1'b1), .SET_W(2)) dut (.ref_clk_i, .rst_i, .instr_valid_i(valid),
        .instr_i(ins), .user_mode_i(usr), .src_a_data_i(a), .src_b_data_i(b),
        .exc_switch_i(exc_sw), .exc_new_set_i(exc_set), .shd_rd_set_i(rd_set),
        .shd_rd_idx_i(rd_idx), .ctl_wr_o(ctl_wr), .ctl_idx_o(ctl_idx), .ctl_data_o(ctl_data),
        .gpr_wr_o(gpr_wr), .gpr_idx_o(gpr_idx), .gpr_data_o(gpr_data), .shd_wr_o(shd_wr),
        .exc_supv_o(supv), .exc_illegal_o(ill), .cur_set_o(cur_set), .prev_set_o(prev_set),
        .shd_rd_data_o(rd_data));
    // A core without shadow sets shares every input, so only the fault, shadow-write and shadow-read outputs differ.
    csx_exec #(.HAS_SHADOW(1'b0), .SET_W(2)) nos (.ref_clk_i, .rst_i, .instr_valid_i(valid),
        .instr_i(ins), .user_mode_i(usr), .src_a_data_i(a), .src_b_data_i(b),
        .exc_switch_i(exc_sw), .exc_new_set_i(exc_set), .shd_rd_set_i(rd_set),
        .shd_rd_idx_i(rd_idx), .ctl_wr_o(), .ctl_idx_o(), .ctl_data_o(), .gpr_wr_o(),
        .gpr_idx_o(), .gpr_data_o(), .shd_wr_o(shd_wr2), .exc_supv_o(), .exc_illegal_o(ill2),
        .cur_set_o(), .prev_set_o(), .shd_rd_data_o());
    function automatic logic [31:0] mk(logic [5:0] x, logic [4:0] ra, rb, rc, n,
                                       logic [5:0] op = OP_RTYPE);
        return {ra, rb, rc, x, n, op};
    endfunction
    task automatic exec(logic [31:0] i, logic u, logic [31:0] va, vb);
        @(posedge ref_clk_i) #1;
        ins = i;
        usr = u;
        a = va;
        b = vb;
        valid = 1'b1;
        @(posedge ref_clk_i) #1;
        valid = 1'b0;
    endtask
    task automatic rd(logic [1:0] s, logic [4:0] x, logic [31:0] e);
        rd_set = s;
        rd_idx = x;
        repeat (2) @(posedge ref_clk_i) #1;
        `CHK(rd_data, e)
    endtask
    task automatic exc(logic [1:0] s);
        @(posedge ref_clk_i) #1;
        exc_sw = 1'b1;
        exc_set = s;
        @(posedge ref_clk_i) #1;
        exc_sw = 1'b0;
    endtask
    task automatic summarize;
        if (errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        #100000;
        errors++;
        summarize();
    end
    initial begin
        rows[0] = '{mk(OPX_XOR, 7, 8, 6, 0), 0, 32'hf0f01234, 32'h0ff04321, 4'b0100, 6,
                    32'hff005115, 0};
        rows[1] = '{mk(OPX_XOR, 1, 2, 31, 0), 1, 32'hffffffff, 32'h0000ffff, 4'b0100, 31,
                    32'hffff0000, 0};
        rows[2] = '{mk(OPX_WR_CTL, 3, 0, 0, 6), 0, 32'h13579bdf, 32'h0, 4'b1000, 6,
                    32'h13579bdf, 0};
        rows[3] = '{mk(OPX_WR_CTL, 9, 21, 17, 31), 0, 32'ha5a55a5a, 32'h1, 4'b1000, 31,
                    32'ha5a55a5a, 0};
        rows[4] = '{mk(OPX_WR_CTL, 3, 0, 0, 6), 1, 32'h11111111, 32'h0, 4'b0001, 0, 0, 0};
        rows[5] = '{mk(OPX_WR_PREV, 7, 0, 3, 0), 0, 32'hcafe0001, 32'h0, 4'b0010, 0, 0, 1};
        rows[6] = '{mk(OPX_WR_PREV, 7, 0, 3, 0), 1, 32'hbad00002, 32'h0, 4'b0001, 0, 0, 1};
        rows[7] = '{mk(6'h1d, 7, 8, 6, 0), 0, 32'h1, 32'h2, 4'b0000, 0, 0, 0};
        rows[8] = '{mk(OPX_XOR, 7, 8, 6, 0, 6'h3c), 0, 32'h1, 32'h2, 4'b0000, 0, 0, 0};
        repeat (2) @(posedge ref_clk_i);
        #1;
        rst_i = 1'b0;
        `CHK({ctl_wr, gpr_wr, shd_wr, supv, ill}, 5'h00)
        `CHK({cur_set, prev_set}, 4'h0)
        foreach (rows[k]) begin
            exec(rows[k].ins, rows[k].usr, rows[k].a, rows[k].b);
            `CHK({ctl_wr, gpr_wr, shd_wr, supv}, rows[k].pls)
            `CHK({ill2, shd_wr2}, {rows[k].ill, 1'b0})
            if (rows[k].pls[3]) begin
                `CHK({ctl_idx, ctl_data}, {rows[k].idx, rows[k].dat})
            end
            if (rows[k].pls[2]) begin
                `CHK({gpr_idx, gpr_data}, {rows[k].idx, rows[k].dat})
            end
        end
        // The refused user-mode write must leave the earlier word in place.
        rd(2'h0, 5'h03, 32'hcafe0001);
        exec(mk(OPX_WR_CTL, 4, 0, 0, 0), 1, 32'h00000c00, 32'h0);
        `CHK(prev_set, 2'h0)
        exec(mk(OPX_WR_CTL, 4, 0, 0, 0), 0, 32'h00000c00, 32'h0);
        `CHK(prev_set, 2'h3)
        `CHK(cur_set, 2'h0)
        exec(mk(OPX_WR_PREV, 0, 0, 0, 0), 0, 32'h0, 32'h0);
        exec(mk(OPX_WR_PREV, 5, 0, 9, 0), 0, 32'h600df00d, 32'h0);
        rd(2'h3, 5'h00, 32'h0);
        rd(2'h3, 5'h09, 32'h600df00d);
        exc(2'h1);
        `CHK({cur_set, prev_set}, {2'h1, 2'h0})
        exc(2'h2);
        `CHK({cur_set, prev_set}, {2'h2, 2'h1})
        exec(mk(OPX_WR_PREV, 5, 0, 4, 0), 0, 32'h0badf00d, 32'h0);
        rd(2'h1, 5'h04, 32'h0badf00d);
        summarize();
    end
endmodule // ctl_shadow_xor_exec_bench
`default_nettype wire
